/* File: hw/qcd_pkg.sv */
// Purpose: shared constants and types for the quadrant clock distribution
// Assumes: four quadrants, eight lines each, 24 edge selectors
// Notes: line letters A..H map to indices 0..7
package qcd_pkg;
    localparam int QUAD_COUNT = 4;
    localparam int LINE_COUNT = 8;
    localparam int SPINE_WIDTH = 4;
    localparam int SOURCE_COUNT = 24;
    localparam int SYNC_STAGES = 2;
    // Quadrant indices
    localparam int UPPER_RIGHT_QUADRANT = 0;
    localparam int LOWER_RIGHT_QUADRANT = 1;
    localparam int LOWER_LEFT_QUADRANT = 2;
    localparam int UPPER_LEFT_QUADRANT = 3;
    // Per-line source choice: 0 = global spine, 1 = half-edge spine
    localparam logic SEL_GLOBAL = 1'b0;
    localparam logic SEL_EDGE = 1'b1;
    localparam logic [7:0] LINE_SEL_RESET = 8'h00;
    localparam logic [7:0] LINE_EN_RESET = 8'h00;

    typedef logic [LINE_COUNT-1:0] qcd_lines_t;

    // Candidate sources entering the network
    typedef struct packed {
        logic [SPINE_WIDTH-1:0] top_src;
        logic [SPINE_WIDTH-1:0] bottom_src;
        logic [LINE_COUNT-1:0] left_src;
        logic [LINE_COUNT-1:0] right_src;
    } qcd_sources_t;

    // Per-quadrant static configuration
    typedef struct packed {
        logic [LINE_COUNT-1:0] line_sel;
        logic [LINE_COUNT-1:0] line_en;
    } qcd_quad_cfg_t;
endpackage : qcd_pkg

/* File: hw/qcd_line_selector.sv */
// Purpose: one 2-to-1 edge clock selector for a single quadrant line
// Assumes: select is static or changes away from the selected edge
// Notes: glitch-free by two-flop handover on the clocked copies
`timescale 1ns/1ps
module qcd_line_selector (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Candidate sources
    input wire logic primary_clock_input_in,
    input wire logic secondary_clock_input_in,
    // Control
    input wire logic select_in,
    input wire logic enable_in,
    // Selected line
    output logic line_out
);
    logic pri_s1_reg;
    logic pri_s2_reg;
    logic sec_s1_reg;
    logic sec_s2_reg;
    logic use_sec_reg;
    logic use_pri_reg;
    logic line_reg;
    wire logic line_next;
    wire logic switch_ok;

    // Switch only when both copies stand low, so no runt pulse escapes
    assign switch_ok = !pri_s2_reg && !sec_s2_reg;
    assign line_next = enable_in &&
        (use_sec_reg ? sec_s2_reg : (use_pri_reg ? pri_s2_reg : 1'b0));

    // Source synchronisers, then glitch-free handover
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pri_s1_reg <= 1'b0;
            pri_s2_reg <= 1'b0;
            sec_s1_reg <= 1'b0;
            sec_s2_reg <= 1'b0;
            use_sec_reg <= 1'b0;
            use_pri_reg <= 1'b1;
            line_reg <= 1'b0;
        end else begin
            pri_s1_reg <= primary_clock_input_in;
            pri_s2_reg <= pri_s1_reg;
            sec_s1_reg <= secondary_clock_input_in;
            sec_s2_reg <= sec_s1_reg;
            if (switch_ok) begin
                use_sec_reg <= select_in;
                use_pri_reg <= !select_in;
            end
            line_reg <= line_next;
        end
    end

    assign line_out = line_reg;
endmodule : qcd_line_selector

/* File: hw/qcd_quadrant_network.sv */
// Purpose: quadrant clock selection and distribution network
// Assumes: source clocks sampled in core_clk_in domain; static config
// Notes: sources are modelled as sampled levels, not real clock trees
//
// Notes on behaviour
// - There are four independent quadrants with eight lines A to H each.
// - Each line comes from the matching global selector or its own edge selector.
// - Taking the global source on a line shuts out the edge source on it.
// - A line's choice in one quadrant does not bind the same line elsewhere.
// - Selected lines feed every clocked element in their quadrant.
// - Top and bottom selectors drive two vertical spines of four lines.
// - The vertical spines join an eight-line horizontal centre spine.
// - Left and right selectors drive their own eight-line horizontal spine.
// - Up to 24 sources enter, at most eight reach any one quadrant.
// - Unused clock segments are disabled and held static.
// - Left selectors reach left quadrants only, right ones right only.
// - A selector passes its first input on 0 and second on 1 without glitch.
`timescale 1ns/1ps
module qcd_quadrant_network (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Candidate clock sources (asynchronous to core_clk_in)
    input wire qcd_pkg::qcd_sources_t sources_in,
    // Static configuration per quadrant
    input wire qcd_pkg::qcd_quad_cfg_t upper_right_quadrant_cfg_in,
    input wire qcd_pkg::qcd_quad_cfg_t lower_right_quadrant_cfg_in,
    input wire qcd_pkg::qcd_quad_cfg_t lower_left_quadrant_cfg_in,
    input wire qcd_pkg::qcd_quad_cfg_t upper_left_quadrant_cfg_in,
    // Quadrant clock lines
    output qcd_pkg::qcd_lines_t upper_right_quadrant_out,
    output qcd_pkg::qcd_lines_t lower_right_quadrant_out,
    output qcd_pkg::qcd_lines_t lower_left_quadrant_out,
    output qcd_pkg::qcd_lines_t upper_left_quadrant_out
);
    logic rst_s1_reg;
    logic rst_s2_reg;
    qcd_pkg::qcd_quad_cfg_t cfg_reg [qcd_pkg::QUAD_COUNT];
    logic cfg_loaded_reg;
    wire qcd_pkg::qcd_lines_t centre_spine;
    wire qcd_pkg::qcd_lines_t left_spine;
    wire qcd_pkg::qcd_lines_t right_spine;
    wire qcd_pkg::qcd_quad_cfg_t cfg_in_arr [qcd_pkg::QUAD_COUNT];
    wire qcd_pkg::qcd_lines_t quad_lines [qcd_pkg::QUAD_COUNT];
    wire logic cfg_take;
    qcd_pkg::qcd_lines_t centre_used_reg;
    qcd_pkg::qcd_lines_t left_used_reg;
    qcd_pkg::qcd_lines_t right_used_reg;
    wire qcd_pkg::qcd_lines_t centre_used_next;
    wire qcd_pkg::qcd_lines_t left_used_next;
    wire qcd_pkg::qcd_lines_t right_used_next;

    // Enabled lines of one quadrant that take the global centre spine
    function automatic qcd_pkg::qcd_lines_t global_lines(input qcd_pkg::qcd_quad_cfg_t cfg);
        return ~cfg.line_sel & cfg.line_en;
    endfunction : global_lines

    // Enabled lines of one quadrant that take its own edge spine
    function automatic qcd_pkg::qcd_lines_t edge_lines(input qcd_pkg::qcd_quad_cfg_t cfg);
        return cfg.line_sel & cfg.line_en;
    endfunction : edge_lines

    // Right-half quadrants hang off the right spine, the rest off the left
    function automatic logic is_right_half(input int quad);
        return (quad == qcd_pkg::UPPER_RIGHT_QUADRANT) ||
            (quad == qcd_pkg::LOWER_RIGHT_QUADRANT);
    endfunction : is_right_half

    // Reset release through two flops
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    // Vertical spines (top lines H..E, bottom D..A) join the centre spine
    assign centre_spine = {sources_in.top_src, sources_in.bottom_src};
    assign left_spine = sources_in.left_src;
    assign right_spine = sources_in.right_src;

    assign cfg_in_arr[qcd_pkg::UPPER_RIGHT_QUADRANT] = upper_right_quadrant_cfg_in;
    assign cfg_in_arr[qcd_pkg::LOWER_RIGHT_QUADRANT] = lower_right_quadrant_cfg_in;
    assign cfg_in_arr[qcd_pkg::LOWER_LEFT_QUADRANT] = lower_left_quadrant_cfg_in;
    assign cfg_in_arr[qcd_pkg::UPPER_LEFT_QUADRANT] = upper_left_quadrant_cfg_in;

    // Single capture strobe, first edge with the internal reset released
    assign cfg_take = rst_s2_reg && !cfg_loaded_reg;

    // Spine segment use, decoded from the incoming config at capture
    assign centre_used_next = global_lines(cfg_in_arr[qcd_pkg::UPPER_RIGHT_QUADRANT]) |
        global_lines(cfg_in_arr[qcd_pkg::LOWER_RIGHT_QUADRANT]) |
        global_lines(cfg_in_arr[qcd_pkg::LOWER_LEFT_QUADRANT]) |
        global_lines(cfg_in_arr[qcd_pkg::UPPER_LEFT_QUADRANT]);
    assign left_used_next = edge_lines(cfg_in_arr[qcd_pkg::LOWER_LEFT_QUADRANT]) |
        edge_lines(cfg_in_arr[qcd_pkg::UPPER_LEFT_QUADRANT]);
    assign right_used_next = edge_lines(cfg_in_arr[qcd_pkg::UPPER_RIGHT_QUADRANT]) |
        edge_lines(cfg_in_arr[qcd_pkg::LOWER_RIGHT_QUADRANT]);

    // Config captured once after reset release; later changes ignored
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg_loaded_reg <= 1'b0;
            for (int q = 0; q < qcd_pkg::QUAD_COUNT; q++) begin
                cfg_reg[q] <= {qcd_pkg::LINE_SEL_RESET, qcd_pkg::LINE_EN_RESET};
            end
        end else if (cfg_take) begin
            cfg_loaded_reg <= 1'b1;
            for (int q = 0; q < qcd_pkg::QUAD_COUNT; q++) begin
                cfg_reg[q] <= cfg_in_arr[q];
            end
        end
    end

    // Segment masks latch with the config, so unused segments stay dark
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            centre_used_reg <= qcd_pkg::LINE_EN_RESET;
            left_used_reg <= qcd_pkg::LINE_EN_RESET;
            right_used_reg <= qcd_pkg::LINE_EN_RESET;
        end else if (cfg_take) begin
            centre_used_reg <= centre_used_next;
            left_used_reg <= left_used_next;
            right_used_reg <= right_used_next;
        end
    end

    // One selector per quadrant line: primary global, secondary own-edge spine
    for (genvar q = 0; q < qcd_pkg::QUAD_COUNT; q++) begin : g_quad
        for (genvar l = 0; l < qcd_pkg::LINE_COUNT; l++) begin : g_line
            // Right quadrants see only the right spine, left only the left
            wire logic edge_src = is_right_half(q) ? right_spine[l] : left_spine[l];
            wire logic edge_used = is_right_half(q) ? right_used_reg[l] : left_used_reg[l];
            wire logic sel_edge = cfg_reg[q].line_sel[l];
            // A line runs only while its spine segment is in use
            wire logic seg_live = sel_edge ? edge_used : centre_used_reg[l];
            wire logic line_enable = cfg_loaded_reg && cfg_reg[q].line_en[l] && seg_live;
            qcd_line_selector qcd_line_selector_i (
                .clk_in(core_clk_in),
                .rst_n_in(rst_s2_reg),
                .primary_clock_input_in(centre_spine[l]),
                .secondary_clock_input_in(edge_src),
                .select_in(sel_edge),
                .enable_in(line_enable),
                .line_out(quad_lines[q][l])
            );
        end
    end

    // Eight lines per quadrant out of 24 candidates
    assign upper_right_quadrant_out = quad_lines[qcd_pkg::UPPER_RIGHT_QUADRANT];
    assign lower_right_quadrant_out = quad_lines[qcd_pkg::LOWER_RIGHT_QUADRANT];
    assign lower_left_quadrant_out = quad_lines[qcd_pkg::LOWER_LEFT_QUADRANT];
    assign upper_left_quadrant_out = quad_lines[qcd_pkg::UPPER_LEFT_QUADRANT];
endmodule : qcd_quadrant_network

/* File: bench/qcd_quadrant_network_assertions.sv */
// Purpose: port checks for the quadrant clock network
// Assumes: config steady across each reset release
// Notes: config copied at the third edge after release, as the design does
`timescale 1ns/1ps
module qcd_quadrant_network_assertions (
    // Clock, reset, sources
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire qcd_pkg::qcd_sources_t sources_in,
    // Config
    input wire qcd_pkg::qcd_quad_cfg_t upper_right_quadrant_cfg_in,
    input wire qcd_pkg::qcd_quad_cfg_t lower_right_quadrant_cfg_in,
    input wire qcd_pkg::qcd_quad_cfg_t lower_left_quadrant_cfg_in,
    input wire qcd_pkg::qcd_quad_cfg_t upper_left_quadrant_cfg_in,
    // Lines
    input wire qcd_pkg::qcd_lines_t upper_right_quadrant_out,
    input wire qcd_pkg::qcd_lines_t lower_right_quadrant_out,
    input wire qcd_pkg::qcd_lines_t lower_left_quadrant_out,
    input wire qcd_pkg::qcd_lines_t upper_left_quadrant_out
);
    logic [3:0] age_reg;
    qcd_pkg::qcd_quad_cfg_t [3:0] cap_reg;
    function automatic logic [7:0] pick(qcd_pkg::qcd_quad_cfg_t c, logic [7:0] e, logic [7:0] g);
        return ((c.line_sel & e) | (~c.line_sel & g)) & c.line_en;
    endfunction : pick
    // Expected lines from the copied config
    wire logic up = age_reg == 4'hf;
    wire logic [7:0] g = {sources_in.top_src, sources_in.bottom_src};
    wire logic [31:0] lines = {upper_left_quadrant_out, lower_left_quadrant_out,
        lower_right_quadrant_out, upper_right_quadrant_out};
    wire logic [31:0] want = {pick(cap_reg[3], sources_in.left_src, g),
        pick(cap_reg[2], sources_in.left_src, g), pick(cap_reg[1], sources_in.right_src, g),
        pick(cap_reg[0], sources_in.right_src, g)};
    wire logic [31:0] ens = {cap_reg[3].line_en, cap_reg[2].line_en, cap_reg[1].line_en,
        cap_reg[0].line_en};
    // Age count keeps the line checks other than a_rst off until capture is long done
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            age_reg <= 4'h0;
        end else if (!up) begin
            age_reg <= age_reg + 4'h1;
        end
    end
    always_ff @(posedge core_clk_in) begin
        if (age_reg == 4'h2) begin
            cap_reg <= {upper_left_quadrant_cfg_in, lower_left_quadrant_cfg_in,
                lower_right_quadrant_cfg_in, upper_right_quadrant_cfg_in};
        end
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_calm;
        up ##0 $stable(sources_in) [*6];
    endsequence
    property p_ur; s_calm |-> lines[7:0] == want[7:0]; endproperty
    a_ur: assert property (p_ur) else $error("upper right lines wrong");
    property p_lr; s_calm |-> lines[15:8] == want[15:8]; endproperty
    a_lr: assert property (p_lr) else $error("lower right lines wrong");
    property p_ll; s_calm |-> lines[23:16] == want[23:16]; endproperty
    a_ll: assert property (p_ll) else $error("lower left lines wrong");
    property p_ul; s_calm |-> lines[31:24] == want[31:24]; endproperty
    a_ul: assert property (p_ul) else $error("upper left lines wrong");
    property p_off; up |-> (lines & ~ens) == 32'h0; endproperty
    a_off: assert property (p_off) else $error("disabled line moved");
    property p_rst; $rose(rst_n_in) |-> (lines == 32'h0) [*3]; endproperty
    a_rst: assert property (p_rst) else $error("lines live before capture");
    property p_quiet; s_calm |=> $stable(lines); endproperty
    a_quiet: assert property (p_quiet) else $error("line glitch on quiet sources");
    property p_mid; s_calm |-> ((lines[7:0] ^ lines[31:24]) & ens[7:0] & ens[31:24]
        & ~(cap_reg[0].line_sel | cap_reg[3].line_sel)) == 8'h0; endproperty
    a_mid: assert property (p_mid) else $error("centre spine differs");
endmodule : qcd_quadrant_network_assertions
bind qcd_quadrant_network qcd_quadrant_network_assertions qcd_quadrant_network_assertions_i (.*);

/* File: bench/qcd_src_model.sv */
// Purpose: edge selector outputs feeding the network
// Assumes: sources move as slow levels
// Notes: no reset; the bench parks it low
`timescale 1ns/1ps
module qcd_src_model (
    // Clock and request
    input wire logic clk_in,
    input wire qcd_pkg::qcd_sources_t next_in,
    // Selector outputs
    output qcd_pkg::qcd_sources_t src_out
);
    // Levels only; fast clocks would stay on top and bottom selectors
    always @(posedge clk_in) begin
        src_out <= next_in;
    end
endmodule : qcd_src_model

/* File: bench/qcd_quadrant_network_tb.sv */
// Purpose: self-checking bench for the quadrant clock network
// Assumes: sources held for many cycles between moves
// Notes: each session loads fresh random config under reset
`timescale 1ns/1ps
module qcd_quadrant_network_tb;
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    qcd_pkg::qcd_sources_t nxt = '0;
    qcd_pkg::qcd_sources_t src;
    qcd_pkg::qcd_quad_cfg_t cfg [4] = '{default: '0};
    qcd_pkg::qcd_lines_t ln [4];
    logic [31:0] note_q [$];
    int err_count = 0;
    int check_count = 0;
    int seed = 73624;
    event look;
    always #25 core_clk_in = ~core_clk_in;
    qcd_src_model qcd_src_model_i (.clk_in(core_clk_in), .next_in(nxt), .src_out(src));
    qcd_quadrant_network qcd_quadrant_network_i (.core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in), .sources_in(src), .upper_right_quadrant_cfg_in(cfg[0]),
        .lower_right_quadrant_cfg_in(cfg[1]), .lower_left_quadrant_cfg_in(cfg[2]),
        .upper_left_quadrant_cfg_in(cfg[3]), .upper_right_quadrant_out(ln[0]),
        .lower_right_quadrant_out(ln[1]), .lower_left_quadrant_out(ln[2]),
        .upper_left_quadrant_out(ln[3]));
    function automatic logic [7:0] pick(qcd_pkg::qcd_quad_cfg_t c, logic [7:0] e, logic [7:0] g);
        return ((c.line_sel & e) | (~c.line_sel & g)) & c.line_en;
    endfunction : pick
    task automatic finish_test();
        if (err_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    // Oldest note against the lines, at a settled moment
    always @(look) begin
        check_count++;
        if ({ln[3], ln[2], ln[1], ln[0]} !== note_q[0]) begin
            err_count++;
            $display("[ERR] lines exp %h got %h", note_q[0], {ln[3], ln[2], ln[1], ln[0]});
        end
        void'(note_q.pop_front());
    end
    // Config loads under reset; the later inverted moves must be ignored
    task automatic session();
        qcd_pkg::qcd_quad_cfg_t h [4];
        logic [7:0] g;
        @(posedge core_clk_in);
        rst_n_in <= 1'b0;
        nxt <= '0;
        for (int q = 0; q < 4; q++) begin
            h[q] = qcd_pkg::qcd_quad_cfg_t'(16'($random(seed)));
            cfg[q] <= h[q];
        end
        repeat (12) @(posedge core_clk_in);
        @(negedge core_clk_in);
        note_q.push_back(32'h0);
        -> look;
        @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        repeat (8) @(posedge core_clk_in);
        for (int i = 0; i < 6; i++) begin
            nxt <= qcd_pkg::qcd_sources_t'(24'($random(seed)));
            cfg[i % 4] <= ~h[i % 4];
            repeat (8) @(posedge core_clk_in);
            @(negedge core_clk_in);
            g = {nxt.top_src, nxt.bottom_src};
            note_q.push_back({pick(h[3], nxt.left_src, g), pick(h[2], nxt.left_src, g),
                pick(h[1], nxt.right_src, g), pick(h[0], nxt.right_src, g)});
            -> look;
            @(posedge core_clk_in);
        end
    endtask : session
    initial begin
        repeat (4) session();
        finish_test();
    end
    initial begin
        #100us;
        err_count++;
        finish_test();
    end
endmodule : qcd_quadrant_network_tb
